/* File: pax_pkg.sv */
// Package for the press auxiliary output block: pin and output carriers,
// register map, status bit layout, operator mode and stroke select codes.
// Assumes a single 100 MHz clock domain and a plain strobe register port.
package pax_pkg;

   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;
   localparam int CODE_W = 8;
   localparam int MODE_W = 3;
   localparam int SEL_W = 2;
   localparam int NUM_MODES = 6;
   localparam int EVT_W = 5;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFS_STATE = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_MASK = 4'h8;

   // Status and mask bit positions
   localparam int EV_FAULT = 0;
   localparam int EV_ESTOP = 1;
   localparam int EV_CURTAIN = 2;
   localparam int EV_INT_STROKE = 3;
   localparam int EV_LOCKOUT = 4;

   // State register bit positions
   localparam int ST_AUX1 = 0;
   localparam int ST_AUX2 = 1;
   localparam int ST_AUX3 = 2;
   localparam int ST_VALVE = 3;
   localparam int ST_LOCKOUT = 4;
   localparam int ST_CODE_LSB = 8;
   localparam int ST_MODE_LSB = 16;

   localparam logic [EVT_W-1:0] MASK_RESET = 5'h00;
   localparam logic [CODE_W-1:0] CODE_RESET = 8'h00;

   // Stroke select switch codes
   localparam logic [SEL_W-1:0] SEL_OFF = 2'h0;
   localparam logic [SEL_W-1:0] SEL_INCH = 2'h1;
   localparam logic [SEL_W-1:0] SEL_SINGLE = 2'h2;
   localparam logic [SEL_W-1:0] SEL_CONT = 2'h3;

   // Operator mode codes
   localparam logic [MODE_W-1:0] MODE_INCH = 3'h0;
   localparam logic [MODE_W-1:0] MODE_SINGLE = 3'h1;
   localparam logic [MODE_W-1:0] MODE_TH_MAINT = 3'h2;
   localparam logic [MODE_W-1:0] MODE_AUTO_SINGLE = 3'h3;
   localparam logic [MODE_W-1:0] MODE_CONT = 3'h4;
   localparam logic [MODE_W-1:0] MODE_BAR = 3'h5;

   typedef enum logic [1:0] {
      LK_CLEAR,
      LK_LOCKED,
      LK_SEEN_OFF
   } pax_lock_t;

   typedef struct packed {
      logic fault;
      logic estop_open;
      logic curtain_blocked;
      logic running;
      logic stroke_cut;
      logic inching;
      logic valve_req;
      logic bar_mode;
      logic key_inch;
      logic cfg_sw8;
      logic serious_err;
      logic lockout_stop;
      logic [CODE_W-1:0] stop_code;
      logic [MODE_W-1:0] op_mode;
      logic [SEL_W-1:0] stroke_sel;
   } pax_pins_t;

   typedef struct packed {
      logic aux1;
      logic aux2;
      logic aux3;
      logic safety_valve_drive;
      logic lockout_relay_open;
      logic lockout_msg;
      logic stop_req;
      logic [NUM_MODES-1:0] mode_indication_terminals;
      logic [CODE_W-1:0] fault_code;
   } pax_outs_t;

   localparam pax_outs_t OUTS_RESET = '{
      aux1: 1'b0, aux2: 1'b0, aux3: 1'b0, safety_valve_drive: 1'b0,
      lockout_relay_open: 1'b0, lockout_msg: 1'b0, stop_req: 1'b0,
      mode_indication_terminals: 6'h00, fault_code: 8'h00};

endpackage : pax_pkg

/* File: pax_sync.sv */
// Two-stage synchroniser for a vector of pin levels.
// Assumes each bit is a slow level; no bus coherence across bits.
`timescale 1ns/10ps
`default_nettype none
module pax_sync #(
   parameter int W = 1
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] meta_r;

   // First stage feeds only the second
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         meta_r <= '0;
         q <= '0;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end

endmodule : pax_sync
`default_nettype wire

/* File: pax_aux_out.sv */
// Press auxiliary output logic: aux outputs, valve drive, lockout and
// mode indication, with a small strobe register port and interrupt.
// Assumes pins are asynchronous levels and the register master is on mclk.
//
// Overview of operation
// - Aux output 1 stays on while no trip condition is present.
// - Aux 1 turns off on fault, e-stop open, or curtain break while running.
// - With switch 8 off, an interrupted stroke turns aux 1 off.
// - Switch 8 on keeps aux 1 on unless fault or e-stop preceded.
// - Switch 8 on, two-hand maintained: inching release is no interruption.
// - Aux output 2 is off normally, on for interrupted stroke or fault.
// - Aux 2 also on when key selects inch and valve is energized.
// - Aux output 3 is off normally, on while the valve is energized.
// - In bar control, aux 3 stays off although the valve is energized.
// - Bar control energizes the safety valve so the crank turns by hand.
// - A serious error enters lockout and shows the lockout message.
// - Lockout clears only after stroke select goes to off, then a mode.
// - Each operator mode drives its own indication output while active.
// - Lockout stop inputs issue stop, report code, open lockout relay.
`timescale 1ns/10ps
`default_nettype none
module pax_aux_out (
   input wire logic mclk,
   input wire logic reset_n,
   input wire pax_pkg::pax_pins_t pins,
   input wire logic [pax_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [pax_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [pax_pkg::DATA_W-1:0] reg_rdata,
   output logic irq,
   output pax_pkg::pax_outs_t outs
);

   pax_pkg::pax_pins_t s;
   logic [$bits(pax_pkg::pax_pins_t)-1:0] s_raw;
   pax_pkg::pax_outs_t outs_nxt;
   pax_pkg::pax_lock_t lock_r;
   pax_pkg::pax_lock_t lock_nxt;
   logic prior_trip_r;
   logic int_stroke;
   logic valve_on;
   logic aux1_trip;
   logic lock_set;
   logic [pax_pkg::EVT_W-1:0] evt;
   logic [pax_pkg::EVT_W-1:0] evt_prev_r;
   logic [pax_pkg::EVT_W-1:0] status_r;
   logic [pax_pkg::EVT_W-1:0] status_nxt;
   logic [pax_pkg::EVT_W-1:0] mask_r;
   logic [pax_pkg::CODE_W-1:0] code_r;

   function automatic logic [pax_pkg::DATA_W-1:0] widen(
      input logic [pax_pkg::EVT_W-1:0] v);
      widen = {{(pax_pkg::DATA_W-pax_pkg::EVT_W){1'b0}}, v};
   endfunction : widen

   function automatic logic hit(input logic [pax_pkg::ADDR_W-1:0] a,
      input logic [pax_pkg::ADDR_W-1:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   // Pin synchroniser
   pax_sync #(.W($bits(pax_pkg::pax_pins_t))) u_sync (
      .mclk(mclk),
      .reset_n(reset_n),
      .d(pins),
      .q(s_raw)
   );
   assign s = pax_pkg::pax_pins_t'(s_raw);

   // Interrupted stroke, excused when inching to top in two-hand maintained with switch 8 on
   assign int_stroke = s.stroke_cut & ~(s.cfg_sw8 & s.inching &
      (s.op_mode == pax_pkg::MODE_TH_MAINT));

   assign valve_on = s.valve_req | s.bar_mode;

   assign lock_set = s.serious_err | s.lockout_stop;

   // Trip terms for aux 1
   always_comb begin
      aux1_trip = s.fault | s.estop_open;
      if (s.curtain_blocked & s.running) begin
         aux1_trip = 1'b1;
      end
      if (int_stroke & ~s.cfg_sw8) begin
         aux1_trip = 1'b1;
      end
      if (int_stroke & s.cfg_sw8 & prior_trip_r) begin
         aux1_trip = 1'b1;
      end
   end

   // Remembers a fault or e-stop ahead of an interrupted stroke
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         prior_trip_r <= 1'b0;
      end else if (s.fault | s.estop_open) begin
         prior_trip_r <= 1'b1;
      end else if (!int_stroke) begin
         prior_trip_r <= 1'b0;
      end
   end

   // Lockout clear sequence: off, then any operating position
   always_comb begin
      lock_nxt = lock_r;
      unique case (lock_r)
         pax_pkg::LK_CLEAR: begin
            if (lock_set) begin
               lock_nxt = pax_pkg::LK_LOCKED;
            end
         end
         pax_pkg::LK_LOCKED: begin
            if (!lock_set && s.stroke_sel == pax_pkg::SEL_OFF) begin
               lock_nxt = pax_pkg::LK_SEEN_OFF;
            end
         end
         pax_pkg::LK_SEEN_OFF: begin
            if (lock_set) begin
               lock_nxt = pax_pkg::LK_LOCKED;
            end else if (s.stroke_sel != pax_pkg::SEL_OFF) begin
               lock_nxt = pax_pkg::LK_CLEAR;
            end
         end
      endcase
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         lock_r <= pax_pkg::LK_CLEAR;
      end else begin
         lock_r <= lock_nxt;
      end
   end

   // Reported stop code, captured when a lockout stop arrives
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         code_r <= pax_pkg::CODE_RESET;
      end else if (s.lockout_stop) begin
         code_r <= s.stop_code;
      end
   end

   // Output terms
   always_comb begin
      outs_nxt = pax_pkg::OUTS_RESET;
      outs_nxt.aux1 = ~aux1_trip;
      outs_nxt.aux2 = int_stroke | s.fault |
         (s.key_inch & valve_on);
      outs_nxt.aux3 = valve_on & ~s.bar_mode;
      outs_nxt.safety_valve_drive = valve_on;
      outs_nxt.lockout_relay_open = (lock_nxt != pax_pkg::LK_CLEAR);
      outs_nxt.lockout_msg = (lock_nxt != pax_pkg::LK_CLEAR);
      outs_nxt.stop_req = s.lockout_stop;
      outs_nxt.fault_code = s.lockout_stop ? s.stop_code : code_r;
      for (int i = 0; i < pax_pkg::NUM_MODES; i++) begin
         outs_nxt.mode_indication_terminals[i] =
            (s.op_mode == i[pax_pkg::MODE_W-1:0]);
      end
   end

   // Registered outputs, no glitches reach the relays
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         outs <= pax_pkg::OUTS_RESET;
      end else begin
         outs <= outs_nxt;
      end
   end

   // Event edges into sticky status
   always_comb begin
      evt = '0;
      evt[pax_pkg::EV_FAULT] = s.fault;
      evt[pax_pkg::EV_ESTOP] = s.estop_open;
      evt[pax_pkg::EV_CURTAIN] = s.curtain_blocked & s.running;
      evt[pax_pkg::EV_INT_STROKE] = int_stroke;
      evt[pax_pkg::EV_LOCKOUT] = lock_set;
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         evt_prev_r <= '0;
      end else begin
         evt_prev_r <= evt;
      end
   end

   // Read clears status; a new event in that cycle wins
   always_comb begin
      status_nxt = status_r;
      if (reg_rd && hit(reg_addr, pax_pkg::OFS_STATUS)) begin
         status_nxt = '0;
      end
      status_nxt = status_nxt | (evt & ~evt_prev_r);
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         status_r <= '0;
      end else begin
         status_r <= status_nxt;
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         mask_r <= pax_pkg::MASK_RESET;
      end else if (reg_wr && hit(reg_addr, pax_pkg::OFS_MASK)) begin
         mask_r <= reg_wdata[pax_pkg::EVT_W-1:0];
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(status_nxt & mask_r);
      end
   end

   // Read data, valid the cycle after the strobe only
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata <= '0;
      end else if (!reg_rd) begin
         reg_rdata <= '0;
      end else if (hit(reg_addr, pax_pkg::OFS_STATE)) begin
         reg_rdata <= '0;
         reg_rdata[pax_pkg::ST_AUX1] <= outs.aux1;
         reg_rdata[pax_pkg::ST_AUX2] <= outs.aux2;
         reg_rdata[pax_pkg::ST_AUX3] <= outs.aux3;
         reg_rdata[pax_pkg::ST_VALVE] <= outs.safety_valve_drive;
         reg_rdata[pax_pkg::ST_LOCKOUT] <= outs.lockout_msg;
         reg_rdata[pax_pkg::ST_CODE_LSB +: pax_pkg::CODE_W] <= code_r;
         reg_rdata[pax_pkg::ST_MODE_LSB +: pax_pkg::MODE_W] <= s.op_mode;
      end else if (hit(reg_addr, pax_pkg::OFS_STATUS)) begin
         reg_rdata <= widen(status_r);
      end else if (hit(reg_addr, pax_pkg::OFS_MASK)) begin
         reg_rdata <= widen(mask_r);
      end else begin
         reg_rdata <= '0;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);

   sequence seq_locked;
      lock_r == pax_pkg::LK_LOCKED;
   endsequence

   sequence seq_off_then_mode;
      (s.stroke_sel == pax_pkg::SEL_OFF && !lock_set) ##1
      (s.stroke_sel != pax_pkg::SEL_OFF && !lock_set);
   endsequence

   chk_aux1_idle: assert property (reset_n && !s.fault &&
      !s.estop_open && !s.curtain_blocked && !s.stroke_cut |=> outs.aux1)
      else $error("aux1 off with no trip");
   chk_aux1_trip: assert property ((s.fault || s.estop_open)
      |=> !outs.aux1)
      else $error("aux1 on during fault");
   chk_aux1_sw8off: assert property (int_stroke && !s.cfg_sw8
      |=> !outs.aux1)
      else $error("aux1 on in stroke, sw8 off");
   chk_aux1_sw8on: assert property (int_stroke && s.cfg_sw8 &&
      !prior_trip_r && !s.fault && !s.estop_open && !s.curtain_blocked
      |=> outs.aux1)
      else $error("aux1 dropped in clean stroke");
   chk_inch_excuse: assert property (s.cfg_sw8 && s.inching &&
      s.op_mode == pax_pkg::MODE_TH_MAINT && !s.fault
      |=> outs.aux2 == $past(s.key_inch && valve_on))
      else $error("inch release flagged");
   chk_aux2_on: assert property ((int_stroke || s.fault ||
      (s.key_inch && valve_on)) |=> outs.aux2)
      else $error("aux2 not on");
   chk_aux3_valve: assert property (valve_on && !s.bar_mode
      |=> outs.aux3 && outs.safety_valve_drive)
      else $error("aux3 off with valve on");
   chk_aux3_bar: assert property (s.bar_mode
      |=> !outs.aux3 && outs.safety_valve_drive)
      else $error("bar mode output wrong");
   chk_lock_enter: assert property (lock_set
      |=> outs.lockout_msg && outs.lockout_relay_open)
      else $error("lockout not shown");
   chk_lock_clear: assert property (seq_locked ##0 seq_off_then_mode
      |=> lock_r == pax_pkg::LK_CLEAR)
      else $error("lockout not cleared");
   chk_lock_hold: assert property (seq_locked ##0
      s.stroke_sel != pax_pkg::SEL_OFF |=> lock_r != pax_pkg::LK_CLEAR)
      else $error("lockout cleared early");
   chk_mode_ind: assert property (s.op_mode == pax_pkg::MODE_AUTO_SINGLE
      |=> outs.mode_indication_terminals ==
      (6'h01 << pax_pkg::MODE_AUTO_SINGLE))
      else $error("mode indication wrong");
   chk_stop_code: assert property (s.lockout_stop
      |=> outs.stop_req && outs.fault_code == $past(s.stop_code))
      else $error("stop code not reported");
   chk_out_stable: assert property (reset_n ##0 $stable(s_raw) [*2]
      |=> $stable(outs))
      else $error("outputs moved with stable inputs");

endmodule : pax_aux_out
`default_nettype wire

/* File: pax_relays.sv */
// Far-side model: customer relays on aux 1 and on the lockout relay.
// Assumes the block's outputs are registered levels on mclk.
`timescale 1ns/10ps
`default_nettype none
module pax_relays (
   input wire logic mclk,
   input wire logic reset_n,
   input wire pax_pkg::pax_outs_t outs,
   output logic beacon_lit,
   output logic motor_run
);
   // Warning beacon lights while aux 1 is open
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         beacon_lit <= 1'b0;
      end else begin
         beacon_lit <= !outs.aux1;
      end
   end

   // Motor starter drops out while the lockout relay is open
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         motor_run <= 1'b0;
      end else begin
         motor_run <= !outs.lockout_relay_open;
      end
   end
endmodule : pax_relays
`default_nettype wire

/* File: test_pax_aux_out.sv */
// Self-checking bench for the press auxiliary output block.
// Assumes pins reach the outputs three edges after they change.
`timescale 1ns/10ps
`default_nettype none
module test_pax_aux_out;
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   pax_pkg::pax_pins_t pins = '0;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic irq;
   pax_pkg::pax_outs_t outs;
   logic beacon_lit;
   logic motor_run;
   int failures = 0;
   int tests_run = 0;
   int cycles = 0;
   pax_pkg::pax_pins_t cur;
   logic [31:0] v;
   logic [7:0] code;

   always #5 mclk = ~mclk;

   pax_aux_out dut (.mclk(mclk), .reset_n(reset_n), .pins(pins),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .outs(outs));

   pax_relays far (.mclk(mclk), .reset_n(reset_n), .outs(outs),
      .beacon_lit(beacon_lit), .motor_run(motor_run));

   // Expected {valve, aux3, aux2, aux1}, no earlier fault latched
   function automatic logic [3:0] exp_aux(input pax_pkg::pax_pins_t p);
      logic cut;
      logic valve;
      cut = p.stroke_cut & !(p.cfg_sw8 & p.inching &
         (p.op_mode == pax_pkg::MODE_TH_MAINT));
      valve = p.valve_req | p.bar_mode;
      return {valve, valve & !p.bar_mode,
         p.fault | cut | (p.key_inch & valve),
         !(p.fault | p.estop_open | (p.curtain_blocked & p.running) |
         (cut & !p.cfg_sw8))};
   endfunction : exp_aux

   function automatic logic [31:0] exp_state(input pax_pkg::pax_pins_t p,
         input logic lock, input logic [7:0] c);
      return {13'h0, p.op_mode, c, 3'h0, lock, exp_aux(p)};
   endfunction : exp_state

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask : check

   task automatic drive(input pax_pkg::pax_pins_t p);
      @(posedge mclk);
      pins <= p;
      repeat (4) @(posedge mclk);
      #1;
   endtask : drive

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask : rd

   function automatic logic [3:0] aux_seen();
      return {outs.safety_valve_drive, outs.aux3, outs.aux2, outs.aux1};
   endfunction : aux_seen

   task automatic finish_test();
      $display("failures=%0d tests_run=%0d", failures, tests_run);
      if (failures == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : finish_test

   // Hang guard
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         finish_test();
      end
   end

   initial begin
      void'($urandom(32'h64DF04C3));
      cur = '0;
      cur.stroke_sel = pax_pkg::SEL_INCH;
      repeat (20) @(posedge mclk);
      reset_n <= 1'b1;
      drive(cur);
      check(32'(aux_seen()), 32'h1);
      rd(pax_pkg::OFS_MASK, v);
      check(v, 32'h0);
      rd(pax_pkg::OFS_STATE, v);
      check(v, exp_state(cur, 1'b0, 8'h00));
      // Random pin mixes, every operator mode in turn
      for (int i = 0; i < 42; i++) begin
         {cur.fault, cur.estop_open, cur.curtain_blocked, cur.running,
            cur.stroke_cut, cur.inching, cur.valve_req, cur.bar_mode,
            cur.key_inch} = 9'($urandom);
         cur.op_mode = 3'(i % 6);
         drive(cur);
         check(32'(aux_seen()), 32'(exp_aux(cur)));
         rd(pax_pkg::OFS_STATE, v);
         check(v, exp_state(cur, 1'b0, 8'h00));
         check(32'(outs.mode_indication_terminals),
            32'h1 << cur.op_mode);
      end
      // Switch 8 on: inching release, plain cut, cut after a fault
      cur = '0;
      cur.stroke_sel = pax_pkg::SEL_INCH;
      cur.cfg_sw8 = 1'b1;
      cur.op_mode = pax_pkg::MODE_TH_MAINT;
      cur.inching = 1'b1;
      cur.stroke_cut = 1'b1;
      drive(cur);
      check(32'(aux_seen()), 32'h1);
      cur.inching = 1'b0;
      drive(cur);
      check(32'(aux_seen()), 32'h3);
      check(32'(beacon_lit), 32'h0);
      cur.fault = 1'b1;
      drive(cur);
      cur.fault = 1'b0;
      drive(cur);
      check(32'(aux_seen()), 32'h2);
      cur.stroke_cut = 1'b0;
      drive(cur);
      check(32'(aux_seen()), 32'h1);
      // Lockout entry and the operator clear sequence
      cur.cfg_sw8 = 1'b0;
      rd(pax_pkg::OFS_STATUS, v);
      cur.serious_err = 1'b1;
      drive(cur);
      check(32'({outs.lockout_msg, outs.lockout_relay_open}), 32'h3);
      check(32'(motor_run), 32'h0);
      cur.serious_err = 1'b0;
      drive(cur);
      check(32'(outs.lockout_msg), 32'h1);
      cur.stroke_sel = pax_pkg::SEL_OFF;
      @(posedge mclk);
      pins <= cur; // One-cycle OFF still counts
      cur.stroke_sel = pax_pkg::SEL_SINGLE;
      drive(cur);
      check(32'({outs.lockout_msg, outs.lockout_relay_open}), 32'h0);
      check(32'(motor_run), 32'h1);
      // Lockout stop input with a random fault code
      code = 8'($urandom);
      cur.lockout_stop = 1'b1;
      cur.stop_code = code;
      drive(cur);
      check(32'({outs.stop_req, outs.lockout_relay_open, outs.lockout_msg}),
         32'h7);
      check(32'(outs.fault_code), 32'(code));
      rd(pax_pkg::OFS_STATE, v);
      check(v, exp_state(cur, 1'b1, code));
      cur.lockout_stop = 1'b0;
      cur.stroke_sel = pax_pkg::SEL_OFF;
      drive(cur);
      check(32'(outs.lockout_msg), 32'h1);
      cur.stroke_sel = pax_pkg::SEL_CONT;
      drive(cur);
      check(32'(outs.lockout_relay_open), 32'h0);
      rd(pax_pkg::OFS_STATUS, v);
      check(v, 32'h1 << pax_pkg::EV_LOCKOUT);
      // Interrupt: masked, unmasked, read-clear; map edges
      cur.fault = 1'b1;
      drive(cur);
      check(32'(irq), 32'h0);
      wr(pax_pkg::OFS_MASK, 32'h1 << pax_pkg::EV_FAULT);
      repeat (2) @(posedge mclk);
      #1;
      check(32'(irq), 32'h1);
      rd(pax_pkg::OFS_MASK, v);
      check(v, 32'h1 << pax_pkg::EV_FAULT);
      rd(4'hC, v);
      check(v, 32'h0);
      wr(pax_pkg::OFS_STATE, 32'hFFFFFFFF);
      rd(pax_pkg::OFS_STATE, v);
      check(v, exp_state(cur, 1'b0, code));
      rd(pax_pkg::OFS_STATUS, v);
      check(v, 32'h1 << pax_pkg::EV_FAULT);
      repeat (2) @(posedge mclk);
      #1;
      check(32'(irq), 32'h0);
      finish_test();
   end
endmodule : test_pax_aux_out
`default_nettype wire
